/* File: sim/epc_drive_model.sv */
`default_nettype none

module epc_drive_model #(
  parameter int DECEL_CYC = 40 // Stop ramp length in clocks, kept short for the run
) (
  input wire logic mclk, // System clock
  input wire logic arst_n, // Async reset, active low
  input wire logic run_req, // Operator run request
  input wire logic slow_req, // Setpoint lowered while running
  output logic drive_running, // Running status
  output logic drive_decel, // Decelerating
  output logic drive_run_cmd // Run command present
);
  timeunit 1ns;
  timeprecision 1ps;

  int ramp_q;

  // Running stays up through the stop ramp, as a real drive ramps down under control
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ramp_q <= 0;
      drive_running <= 1'b0;
      drive_decel <= 1'b0;
      drive_run_cmd <= 1'b0;
    end else begin
      drive_run_cmd <= run_req;
      if (run_req) begin
        drive_running <= 1'b1;
        drive_decel <= slow_req; // Setpoint ramp-down keeps the run command present
        ramp_q <= DECEL_CYC;
      end else if (ramp_q > 0) begin
        drive_decel <= 1'b1;
        ramp_q <= ramp_q - 1;
      end else begin
        drive_running <= 1'b0;
        drive_decel <= 1'b0;
      end
    end
  end
endmodule : epc_drive_model

`default_nettype wire

/* File: sim/tb_top.sv */
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk, arst_n, wb_cyc, wb_stb, wb_we, wb_ack, run_req, slow_req;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r, rdat;
  logic [2:0] on_cmd, act;
  logic [3:0] bsel = 4'hF;
  logic [15:0] out1, out2, out3, sa;
  wire logic running, decel, run_cmd;
  int bad_count = 0;
  int check_count = 0;
  logic [5:0] mtab [9] = '{6'h00, 6'h01, 6'h02, 6'h0B, 6'h0C, 6'h15, 6'h16, 6'h1F, 6'h20};
  logic [5:0] htab [3] = '{6'h0B, 6'h1F, 6'h15};
  logic [6:0] stab [4] = '{7'h00, 7'h03, 7'h04, 7'h70};

  epc_top uut (.mclk(mclk), .arst_n(arst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack), .drive_running(running), .drive_decel(decel), .drive_run_cmd(run_cmd),
    .aux_loop1_on_cmd(on_cmd[0]), .aux_loop2_on_cmd(on_cmd[1]), .aux_loop3_on_cmd(on_cmd[2]),
    .aux_loop1_out(out1), .aux_loop2_out(out2), .aux_loop3_out(out3), .aux_loop_active(act));

  epc_drive_model drv (.mclk(mclk), .arst_n(arst_n), .run_req(run_req), .slow_req(slow_req),
    .drive_running(running), .drive_decel(decel), .drive_run_cmd(run_cmd));

  // Clock at 50 MHz
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One classic cycle; ack is sampled at the edge, so no count of cycles is assumed
  task automatic bus(input logic we, input int ch, input logic [2:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= 8'(ch * 32) + {3'h0, idx, 2'h0};
    wb_sel <= bsel;
    wb_dat_w <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    rdat = wb_dat_r;
    if (n >= 50) chk("ack", 32'h1, 32'h0);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : bus

  task automatic rdc(input int ch, input logic [2:0] idx, input logic [31:0] e, input string nm);
    bus(1'b0, ch, idx, 32'h0);
    chk(nm, e, rdat);
  endtask : rdc

  function automatic logic exp_act(input logic [5:0] m, input logic on, input logic run);
    case (m)
      6'h01, 6'h02: return 1'b1;
      6'h0B, 6'h0C: return run;
      6'h15, 6'h16: return on;
      6'h1F, 6'h20: return on & run;
      default: return 1'b0;
    endcase
  endfunction : exp_act

  // Watchdog well beyond the few thousand cycles the tests need
  initial begin
    repeat (30000) @(posedge mclk);
    bad_count++;
    end_sim();
  end

  initial begin
    {arst_n, wb_cyc, wb_stb, wb_we, run_req, slow_req} = 6'h00;
    {wb_adr, wb_sel, wb_dat_w, on_cmd} = 47'h0;
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    // Reset values, range limits and unmapped space
    rdc(2, epc_pkg::REG_KP, 32'h00000100, "kp reset");
    rdc(1, epc_pkg::REG_MODE, 32'h0, "mode reset");
    bus(1'b1, 3, 3'h0, 32'hFFFFFFFF);
    rdc(3, 3'h0, 32'h0, "unmapped");
    bus(1'b1, 0, epc_pkg::REG_MODE, 32'h20);
    bus(1'b1, 0, epc_pkg::REG_MODE, 32'h21);
    rdc(0, epc_pkg::REG_MODE, 32'h20, "mode limit");
    foreach (stab[i]) begin
      bus(1'b1, 1, epc_pkg::REG_SRC, {25'h0, stab[i]});
      rdc(1, epc_pkg::REG_SRC, {25'h0, stab[i]}, "source");
    end
    bus(1'b1, 1, epc_pkg::REG_SRC, 32'h71);
    rdc(1, epc_pkg::REG_SRC, 32'h70, "source limit");
    // Lane select: only the high byte of a gain lands, a mode needs lane 0
    bsel = 4'h2;
    bus(1'b1, 2, epc_pkg::REG_KP, 32'h000003FF);
    bus(1'b1, 1, epc_pkg::REG_MODE, 32'h01);
    bsel = 4'hF;
    rdc(2, epc_pkg::REG_KP, 32'h0300, "kp lane");
    rdc(1, epc_pkg::REG_MODE, 32'h0, "mode lane");
    $display("test registers done");
    // Every mode against every ON and running combination; other channels stay off
    foreach (mtab[i]) begin
      bus(1'b1, 0, epc_pkg::REG_MODE, {26'h0, mtab[i]});
      for (int c = 0; c < 4; c++) begin
        on_cmd <= {3{c[0]}};
        run_req <= c[1];
        repeat (50) @(posedge mclk);
        chk("active", {29'h0, 2'h0, exp_act(mtab[i], c[0], c[1])}, {29'h0, act});
        bus(1'b0, 0, epc_pkg::REG_STATUS, 32'h0);
        chk("status", {27'h0, c[1], c[0], 1'b0, mtab[i] != 6'h00 && !mtab[i][0],
          exp_act(mtab[i], c[0], c[1])}, rdat & 32'h1B);
      end
    end
    $display("test modes done");
    // Channel 1 stays in mode 32 with ON and running high: feedback above command
    bus(1'b1, 0, epc_pkg::REG_FEEDBACK, 32'h32);
    // Proportional action, normal then inverse, then idle output
    bus(1'b1, 1, epc_pkg::REG_SETPOINT, 32'h64);
    bus(1'b1, 1, epc_pkg::REG_MODE, 32'h01);
    repeat (8) @(posedge mclk);
    chk("out normal", 32'h64, {16'h0, out2});
    chk("out one", 32'h32, {16'h0, out1});
    chk("active two", 32'h3, {29'h0, act});
    bus(1'b1, 1, epc_pkg::REG_MODE, 32'h02);
    repeat (8) @(posedge mclk);
    rdc(1, epc_pkg::REG_OUTPUT, 32'hFF9C, "out inverse");
    bus(1'b1, 1, epc_pkg::REG_MODE, 32'h00);
    repeat (8) @(posedge mclk);
    chk("out idle", 32'h0, {16'h0, out2});
    $display("test action done");
    // Integral freeze only on a stop ramp in running-interlocked modes
    bus(1'b1, 2, epc_pkg::REG_KI, 32'h100);
    bus(1'b1, 2, epc_pkg::REG_SETPOINT, 32'h1);
    foreach (htab[i]) begin
      bus(1'b1, 2, epc_pkg::REG_MODE, {26'h0, htab[i]});
      slow_req <= 1'b1;
      run_req <= 1'b1;
      repeat (20) @(posedge mclk);
      rdc(2, epc_pkg::REG_STATUS, 32'h19, "ramp no hold");
      sa = out3;
      repeat (4) @(posedge mclk);
      chk("integrating", 32'h1, {31'h0, out3 !== sa});
      run_req <= 1'b0;
      repeat (6) @(posedge mclk);
      bus(1'b0, 2, epc_pkg::REG_STATUS, 32'h0);
      chk("stop hold", {29'h0, i < 2, 2'h1}, rdat & 32'h5);
      sa = out3;
      repeat (10) @(posedge mclk);
      chk("frozen", {31'h0, i < 2}, {31'h0, out3 === sa});
      repeat (50) @(posedge mclk);
    end
    $display("test hold done");
    end_sim();
  end
endmodule : tb_top

`default_nettype wire

/* File: src/epc_loop.sv */
`default_nettype none

module epc_loop (
  input wire logic mclk, // System clock
  input wire logic arst_n, // Async reset, active low
  input wire logic en, // Channel operating
  input wire logic inverse, // Inverse action
  input wire logic hold, // Freeze integral term
  input wire logic [15:0] setpoint, // Command value, signed
  input wire logic [15:0] feedback, // Feedback value, signed
  input wire logic [15:0] kp, // Proportional gain Q8.8
  input wire logic [15:0] ki, // Integral gain Q8.8
  output logic [15:0] out_q // Loop output, signed
);

  logic signed [16:0] err_raw;
  logic signed [17:0] err;
  logic signed [34:0] p_term;
  logic signed [34:0] i_step;
  logic signed [39:0] integ_q;
  logic signed [39:0] integ_sum;
  logic signed [39:0] integ_d;
  logic signed [39:0] total;
  logic signed [31:0] scaled;

  // Deviation, negated for inverse action
  always_comb begin
    err_raw = $signed({setpoint[15], setpoint}) - $signed({feedback[15], feedback});
    err = inverse ? -$signed({err_raw[16], err_raw}) : $signed({err_raw[16], err_raw});
    p_term = err * $signed({1'b0, kp});
    i_step = err * $signed({1'b0, ki});
  end

  // Integrator clamps so a long deviation cannot wind the output out of range
  always_comb begin
    integ_sum = integ_q + 40'(i_step);
    if (integ_sum > epc_pkg::INTEG_MAX) begin
      integ_d = epc_pkg::INTEG_MAX;
    end else if (integ_sum < epc_pkg::INTEG_MIN) begin
      integ_d = epc_pkg::INTEG_MIN;
    end else begin
      integ_d = integ_sum;
    end
    total = integ_q + 40'(p_term);
    scaled = 32'(total >>> epc_pkg::GAIN_SHIFT);
  end

  // Integral state: cleared when idle, frozen on hold
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      integ_q <= '0;
    end else if (!en) begin
      integ_q <= '0;
    end else if (!hold) begin
      integ_q <= integ_d;
    end
  end

  // Saturated output register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      out_q <= epc_pkg::VAL_RST;
    end else if (!en) begin
      out_q <= epc_pkg::VAL_RST;
    end else if (scaled > epc_pkg::OUT_MAX) begin
      out_q <= 16'h7FFF;
    end else if (scaled < epc_pkg::OUT_MIN) begin
      out_q <= 16'h8000;
    end else begin
      out_q <= scaled[15:0];
    end
  end

  a_integ_frozen: assert property (@(posedge mclk) disable iff (!arst_n)
    en && hold && $past(en) |=> $stable(integ_q))
    else $error("integral moved while held");
  a_idle_cleared: assert property (@(posedge mclk) disable iff (!arst_n)
    !en |=> integ_q == 40'sh0 && out_q == 16'h0000)
    else $error("idle channel state not cleared");

endmodule : epc_loop

`default_nettype wire

/* File: src/epc_pkg.sv */
`default_nettype none

package epc_pkg;

  // Channel count and bus geometry
  localparam int CH_N = 3;
  localparam int ADR_W = 8;
  localparam int CH_LSB = 5;
  localparam logic [1:0] CH_LAST = 2'h2;

  // Register word index inside one channel window (byte address = ch*0x20 + idx*4)
  localparam logic [2:0] REG_MODE = 3'h0;
  localparam logic [2:0] REG_SRC = 3'h1;
  localparam logic [2:0] REG_SETPOINT = 3'h2;
  localparam logic [2:0] REG_FEEDBACK = 3'h3;
  localparam logic [2:0] REG_KP = 3'h4;
  localparam logic [2:0] REG_KI = 3'h5;
  localparam logic [2:0] REG_OUTPUT = 3'h6;
  localparam logic [2:0] REG_STATUS = 3'h7;

  // Status field positions
  localparam int ST_ACTIVE = 0;
  localparam int ST_INVERSE = 1;
  localparam int ST_HOLD = 2;
  localparam int ST_ON_CMD = 3;
  localparam int ST_RUNNING = 4;

  // Mode codes
  localparam logic [5:0] MODE_OFF = 6'h00;
  localparam logic [5:0] MODE_NORM = 6'h01;
  localparam logic [5:0] MODE_INV = 6'h02;
  localparam logic [5:0] MODE_RUN_NORM = 6'h0B;
  localparam logic [5:0] MODE_RUN_INV = 6'h0C;
  localparam logic [5:0] MODE_ON_NORM = 6'h15;
  localparam logic [5:0] MODE_ON_INV = 6'h16;
  localparam logic [5:0] MODE_BOTH_NORM = 6'h1F;
  localparam logic [5:0] MODE_BOTH_INV = 6'h20;
  localparam logic [7:0] MODE_MAX = 8'h20;

  // Command source codes
  localparam logic [6:0] SRC_KEYPAD = 7'h00;
  localparam logic [6:0] SRC_UPDOWN = 7'h03;
  localparam logic [6:0] SRC_COMM = 7'h04;
  localparam logic [7:0] SRC_MAX = 8'h70;

  // Reset values
  localparam logic [5:0] MODE_RST = 6'h00;
  localparam logic [6:0] SRC_RST = 7'h00;
  localparam logic [15:0] KP_RST = 16'h0100;
  localparam logic [15:0] KI_RST = 16'h0000;
  localparam logic [15:0] VAL_RST = 16'h0000;

  // Loop arithmetic: gains are Q8.8, integrator clamp keeps output reachable
  localparam int GAIN_SHIFT = 8;
  localparam logic signed [39:0] INTEG_MAX = 40'sh00007FFFFF;
  localparam logic signed [39:0] INTEG_MIN = 40'shFFFF800000;
  localparam logic signed [31:0] OUT_MAX = 32'sh00007FFF;
  localparam logic signed [31:0] OUT_MIN = 32'shFFFF8000;

endpackage : epc_pkg

`default_nettype wire

/* File: src/epc_top.sv */
// How it works
// - Three independent auxiliary loops, each with own mode and own ON command.
// - Mode accepts 0..32; zero keeps the channel disabled.
// - Mode 1 runs always with normal action; mode 2 with inverse action.
// - Modes 11 and 12 operate only while drive running status is on.
// - Modes 21 and 22 operate only while the channel ON command is on.
// - Modes 31 and 32 need both ON command and running status.
// - Running-interlocked modes freeze the integral term during deceleration.
// - Freeze only while decelerating to stop after run command removal.
// - No freeze when deceleration comes from a setpoint change.
// - Active loop compares feedback with command and reduces the deviation.
// - Per-channel command source accepts 0..112; 0 keypad, 3 up/down, 4 link.
//
// Chosen here: the placing of the registers and the Wishbone register port.

`default_nettype none

module epc_top (
  input wire logic mclk, // System clock, 50 MHz
  input wire logic arst_n, // Async reset, active low
  input wire logic wb_cyc, // Wishbone cycle
  input wire logic wb_stb, // Wishbone strobe
  input wire logic wb_we, // Wishbone write enable
  input wire logic [7:0] wb_adr, // Wishbone byte address
  input wire logic [3:0] wb_sel, // Wishbone byte lanes
  input wire logic [31:0] wb_dat_w, // Wishbone write data
  output logic [31:0] wb_dat_r, // Wishbone read data
  output logic wb_ack, // Wishbone acknowledge
  input wire logic drive_running, // Drive running status, async
  input wire logic drive_decel, // Drive decelerating, async
  input wire logic drive_run_cmd, // Drive run command present, async
  input wire logic aux_loop1_on_cmd, // Channel 1 ON command, async
  input wire logic aux_loop2_on_cmd, // Channel 2 ON command, async
  input wire logic aux_loop3_on_cmd, // Channel 3 ON command, async
  output logic [15:0] aux_loop1_out, // Channel 1 output
  output logic [15:0] aux_loop2_out, // Channel 2 output
  output logic [15:0] aux_loop3_out, // Channel 3 output
  output logic [2:0] aux_loop_active // Per-channel operating flags
);

  localparam int N = epc_pkg::CH_N;

  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic [2:0] on_s;
  logic run_s;
  logic decel_s;
  logic runcmd_s;
  logic [5:0] mode_q [N];
  logic [6:0] src_q [N];
  logic [15:0] sp_q [N];
  logic [15:0] fb_q [N];
  logic [15:0] kp_q [N];
  logic [15:0] ki_q [N];
  logic [15:0] out_w [N];
  logic [2:0] active_q;
  logic [2:0] active_d;
  logic [2:0] inv_q;
  logic [2:0] inv_d;
  logic [2:0] hold_q;
  logic [2:0] hold_d;
  logic req;
  logic [1:0] ch;
  logic [2:0] idx;
  logic hit;
  logic [31:0] rd_d;

  // Mode decode: gating conditions per mode group
  function automatic logic mode_active(input logic [5:0] m, input logic run, input logic on);
    unique case (m)
      epc_pkg::MODE_NORM, epc_pkg::MODE_INV: mode_active = 1'b1;
      epc_pkg::MODE_RUN_NORM, epc_pkg::MODE_RUN_INV: mode_active = run;
      epc_pkg::MODE_ON_NORM, epc_pkg::MODE_ON_INV: mode_active = on;
      epc_pkg::MODE_BOTH_NORM, epc_pkg::MODE_BOTH_INV: mode_active = on & run;
      default: mode_active = 1'b0;
    endcase
  endfunction : mode_active

  function automatic logic mode_inverse(input logic [5:0] m);
    mode_inverse = (m == epc_pkg::MODE_INV) || (m == epc_pkg::MODE_RUN_INV) ||
      (m == epc_pkg::MODE_ON_INV) || (m == epc_pkg::MODE_BOTH_INV);
  endfunction : mode_inverse

  function automatic logic mode_interlocked(input logic [5:0] m);
    mode_interlocked = (m == epc_pkg::MODE_RUN_NORM) || (m == epc_pkg::MODE_RUN_INV) ||
      (m == epc_pkg::MODE_BOTH_NORM) || (m == epc_pkg::MODE_BOTH_INV);
  endfunction : mode_interlocked

  // Byte-lane merge for 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  // Drive-side pins come from another domain: two flops before use
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
    end else begin
      sync1_q <= {drive_run_cmd, drive_decel, drive_running,
                  aux_loop3_on_cmd, aux_loop2_on_cmd, aux_loop1_on_cmd};
      sync2_q <= sync1_q;
    end
  end

  // Synced copies; only the second stage reads the first
  assign on_s = sync2_q[2:0];
  assign run_s = sync2_q[3];
  assign decel_s = sync2_q[4];
  assign runcmd_s = sync2_q[5];

  // Bus decode: 32-byte window per channel, word per register
  assign req = wb_cyc && wb_stb && !wb_ack;
  assign ch = wb_adr[epc_pkg::CH_LSB +: 2];
  assign idx = wb_adr[4:2];
  assign hit = !wb_adr[epc_pkg::ADR_W - 1] && (ch <= epc_pkg::CH_LAST);

  // Per-channel gating, action sense and integral freeze
  always_comb begin
    for (int i = 0; i < N; i++) begin
      active_d[i] = mode_active(mode_q[i], run_s, on_s[i]);
      inv_d[i] = mode_inverse(mode_q[i]);
      // Stop deceleration only: a setpoint ramp-down keeps the run command
      hold_d[i] = mode_interlocked(mode_q[i]) && decel_s && !runcmd_s;
    end
  end

  // Gate state registered so outputs come from flops
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      active_q <= 3'h0;
      inv_q <= 3'h0;
      hold_q <= 3'h0;
    end else begin
      active_q <= active_d;
      inv_q <= inv_d;
      hold_q <= hold_d;
    end
  end

  // Flag port taken straight from the gate flops
  assign aux_loop_active = active_q;

  // Register writes; out-of-range mode or source codes are dropped
  // A write lands at the taken edge, one cycle before the master sees ack
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < N; i++) begin
        mode_q[i] <= epc_pkg::MODE_RST;
        src_q[i] <= epc_pkg::SRC_RST;
        sp_q[i] <= epc_pkg::VAL_RST;
        fb_q[i] <= epc_pkg::VAL_RST;
        kp_q[i] <= epc_pkg::KP_RST;
        ki_q[i] <= epc_pkg::KI_RST;
      end
    end else if (req && wb_we && hit) begin
      unique case (idx)
        epc_pkg::REG_MODE: begin
          if (wb_sel[0] && wb_dat_w[7:0] <= epc_pkg::MODE_MAX) begin
            mode_q[ch] <= wb_dat_w[5:0];
          end
        end
        epc_pkg::REG_SRC: begin
          if (wb_sel[0] && wb_dat_w[7:0] <= epc_pkg::SRC_MAX) begin
            src_q[ch] <= wb_dat_w[6:0];
          end
        end
        epc_pkg::REG_SETPOINT: sp_q[ch] <= merge16(sp_q[ch], wb_dat_w, wb_sel);
        epc_pkg::REG_FEEDBACK: fb_q[ch] <= merge16(fb_q[ch], wb_dat_w, wb_sel);
        epc_pkg::REG_KP: kp_q[ch] <= merge16(kp_q[ch], wb_dat_w, wb_sel);
        epc_pkg::REG_KI: ki_q[ch] <= merge16(ki_q[ch], wb_dat_w, wb_sel);
        default: ; // Output and status are read-only
      endcase
    end
  end

  // Read mux; unmapped addresses read zero but still acknowledge
  always_comb begin
    rd_d = 32'h00000000;
    if (hit) begin
      unique case (idx)
        epc_pkg::REG_MODE: rd_d = {26'h0, mode_q[ch]};
        epc_pkg::REG_SRC: rd_d = {25'h0, src_q[ch]};
        epc_pkg::REG_SETPOINT: rd_d = {16'h0, sp_q[ch]};
        epc_pkg::REG_FEEDBACK: rd_d = {16'h0, fb_q[ch]};
        epc_pkg::REG_KP: rd_d = {16'h0, kp_q[ch]};
        epc_pkg::REG_KI: rd_d = {16'h0, ki_q[ch]};
        epc_pkg::REG_OUTPUT: rd_d = {16'h0, out_w[ch]};
        epc_pkg::REG_STATUS: begin
          rd_d[epc_pkg::ST_ACTIVE] = active_q[ch];
          rd_d[epc_pkg::ST_INVERSE] = inv_q[ch];
          rd_d[epc_pkg::ST_HOLD] = hold_q[ch];
          rd_d[epc_pkg::ST_ON_CMD] = on_s[ch];
          rd_d[epc_pkg::ST_RUNNING] = run_s;
        end
      endcase
    end
  end

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack <= 1'b0;
      wb_dat_r <= 32'h00000000;
    end else begin
      wb_ack <= req;
      if (req) begin
        wb_dat_r <= rd_d;
      end
    end
  end

  // One loop engine per channel
  for (genvar g = 0; g < N; g++) begin : g_loop
    epc_loop u_loop (
      .mclk(mclk),
      .arst_n(arst_n),
      .en(active_q[g]),
      .inverse(inv_q[g]),
      .hold(hold_q[g]),
      .setpoint(sp_q[g]),
      .feedback(fb_q[g]),
      .kp(kp_q[g]),
      .ki(ki_q[g]),
      .out_q(out_w[g])
    );
  end

  // Loop outputs leave straight from the registers inside each engine
  assign aux_loop1_out = out_w[0];
  assign aux_loop2_out = out_w[1];
  assign aux_loop3_out = out_w[2];

  // Checks on channel 1 stand for all three identical slices
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  a_mode_zero_off: assert property (mode_q[0] == epc_pkg::MODE_OFF |=> !active_q[0])
    else $error("mode zero channel active");
  a_mode_in_range: assert property ({2'h0, mode_q[0]} <= epc_pkg::MODE_MAX)
    else $error("mode above range");
  a_uncond_on: assert property (
    (mode_q[0] == epc_pkg::MODE_NORM || mode_q[0] == epc_pkg::MODE_INV) |=> active_q[0])
    else $error("unconditional mode not active");
  a_run_interlock: assert property (
    mode_q[0] == epc_pkg::MODE_RUN_NORM && !run_s |=> !active_q[0])
    else $error("run interlock ignored");
  a_on_cmd_gate: assert property (
    mode_q[0] == epc_pkg::MODE_ON_INV |=> active_q[0] == $past(on_s[0]))
    else $error("on command gate wrong");
  a_both_gate: assert property (
    mode_q[0] == epc_pkg::MODE_BOTH_NORM |=> active_q[0] == $past(on_s[0] & run_s))
    else $error("combined gate wrong");
  a_hold_stop: assert property (
    mode_q[0] == epc_pkg::MODE_RUN_INV && decel_s && !runcmd_s |=> hold_q[0])
    else $error("no hold in stop deceleration");
  a_no_hold_ramp: assert property (decel_s && runcmd_s |=> !hold_q[0])
    else $error("hold during setpoint ramp");
  a_no_hold_plain: assert property (
    mode_q[0] == epc_pkg::MODE_ON_NORM |=> !hold_q[0])
    else $error("hold in non-interlocked mode");
  a_inverse_sense: assert property (
    mode_q[0] == epc_pkg::MODE_BOTH_INV |=> inv_q[0])
    else $error("inverse action missing");
  a_src_range: assert property ({1'h0, src_q[0]} <= epc_pkg::SRC_MAX)
    else $error("source above range");
  a_ack_pulse: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack ##1 !wb_ack)
    else $error("ack not a single pulse");
  // Only a stop ramp may hold; without deceleration the integrator is never frozen
  a_hold_needs_decel: assert property (!decel_s |=> !hold_q[0])
    else $error("hold without deceleration");
  a_run_inverse: assert property (
    mode_q[0] == epc_pkg::MODE_RUN_INV |=> active_q[0] == $past(run_s))
    else $error("run interlock wrong in inverse mode");
  a_normal_sense: assert property (
    mode_q[0] == epc_pkg::MODE_ON_NORM |=> !inv_q[0])
    else $error("normal action inverted");
  // Channel 2 gets two checks and channel 3 one, so a wiring slip between them shows up
  a_ch2_uncond: assert property (
    mode_q[1] == epc_pkg::MODE_NORM |=> active_q[1])
    else $error("channel 2 not active");
  a_ch3_own_gate: assert property (
    mode_q[2] == epc_pkg::MODE_ON_NORM |=> active_q[2] == $past(on_s[2]))
    else $error("channel 3 gate wrong");
  a_ch2_idle_out: assert property (!active_q[1] |=> aux_loop2_out == 16'h0000)
    else $error("idle channel 2 output not zero");
  // Refused writes must leave the register as it was
  a_mode_drop: assert property (
    req && wb_we && hit && ch == 2'h0 && idx == epc_pkg::REG_MODE &&
    wb_dat_w[7:0] > epc_pkg::MODE_MAX |=> $stable(mode_q[0]))
    else $error("out-of-range mode stored");
  a_unmapped_zero: assert property (req && !wb_we && !hit |=> wb_dat_r == 32'h00000000)
    else $error("unmapped read not zero");

  c_ch_running: cover property (mode_q[0] == epc_pkg::MODE_RUN_NORM && active_q[0]);
  c_ch_hold: cover property (hold_q[0] && active_q[0]);
  c_on_cmd_drop: cover property (mode_q[1] == epc_pkg::MODE_ON_NORM && $fell(active_q[1]));
  c_bus_write: cover property (wb_ack && wb_we);
  c_inverse_run: cover property (inv_q[0] && active_q[0]);

endmodule : epc_top

`default_nettype wire
